/* tb/tb_top.sv */
// Self-checking bench for the triple rail sequencer with a power stage model.
// Assumes a 50 MHz clock and a shortened soft-start count for simulation.
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    localparam int SS_SIM = 2550;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic pd_n = 1'b1;
    logic trip = 1'b0;
    logic [3:0] force_low = 4'h0;
    logic [7:0] delay = 8'h04;
    logic [3:0] rail_up;
    logic ref_en, ref_pd, boost_en, boost_sw, inv_en, inv_hi, inv_lo;
    logic dbl_en, dbl_lo, dbl_hi, rdy_out, rdy_oe;
    logic [7:0] inv_ramp, dbl_ramp;
    logic [3:0] fault_flags;
    logic [4:0] seq_vec;
    logic [4:0] seen_q = 5'h00;
    logic [4:0] exp_q[$];
    logic rdy_wire;
    int err_total = 0;
    int checks_done = 0;
    int cyc = 0;
    int k, t0, hi_cnt, pick, rnd;

    always #10 clk = ~clk;
    always @(posedge clk) cyc++;
    assign seq_vec = {ref_en, boost_en, inv_en, dbl_en, rdy_oe};
    // Open-drain pin with its pull-up.
    assign rdy_wire = rdy_oe ? rdy_out : 1'b1;

    trs_sequencer #(.SS_CYCLES(SS_SIM)) i_dut (
        .clk(clk), .rst(rst), .power_down_n_input(pd_n),
        .ref_above_powerup(rail_up[0]), .ref_above_fault(rail_up[0]),
        .boost_feedback_node_in_reg(rail_up[1]),
        .boost_feedback_node_above_fault(rail_up[1]),
        .negative_pump_feedback_node_below_start(rail_up[2]),
        .negative_pump_feedback_node_below_fault(rail_up[2]),
        .positive_pump_feedback_node_above_ready(rail_up[3]),
        .positive_pump_feedback_node_above_fault(rail_up[3]),
        .boost_trip(trip), .ref_enable(ref_en), .ref_pulldown(ref_pd),
        .boost_enable(boost_en), .boost_switch_on(boost_sw),
        .inverting_enable(inv_en), .inverting_high_side_on(inv_hi),
        .inverting_low_side_on(inv_lo), .doubling_enable(dbl_en),
        .doubling_low_side_on(dbl_lo), .doubling_high_side_on(dbl_hi),
        .inverting_ramp(inv_ramp), .doubling_ramp(dbl_ramp),
        .ready_n_out(rdy_out), .ready_n_oe(rdy_oe), .fault_flags(fault_flags)
    );

    trs_stage_model i_stage (
        .clk(clk), .rst(rst),
        .rail_enable({dbl_en, inv_en, boost_en, ref_en}),
        .force_low(force_low), .delay_cycles(delay), .rail_up(rail_up)
    );

    // ------------------------------------------------------------------
    // Compare and closing tasks
    // ------------------------------------------------------------------
    task automatic check_vec(input logic [4:0] exp, input logic [4:0] got, input string what);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t %s: got %b want %b", $time, what, got, exp);
        end
    endtask : check_vec

    task automatic check_num(input int exp, input int got, input string what);
        checks_done++;
        if (got != exp) begin
            err_total++;
            $display("[ERR] t=%0t %s: got %0d want %0d", $time, what, got, exp);
        end
    endtask : check_num

    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    // ------------------------------------------------------------------
    // Stimulus helpers
    // ------------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // Notes the enable pattern with n leading rails on.
    task automatic push_ones(input int n);
        exp_q.push_back(~(5'b11111 >> n));
    endtask : push_ones

    // Waits, bounded, until every noted step has been seen.
    task automatic drain;
        for (int i = 0; i < 5000 && exp_q.size() > 0; i++) tick(1);
        check_num(0, exp_q.size(), "steps left over");
    endtask : drain

    // Each climb draws a fresh, sometimes prompt, sometimes slow delay.
    task automatic climb_from(input int n);
        delay = 8'(1 + $urandom % 40);
        for (int i = n + 1; i <= 5; i++) push_ones(i);
    endtask : climb_from

    // ------------------------------------------------------------------
    // Scoreboard: compares each change of the enable pattern in order
    // ------------------------------------------------------------------
    always @(negedge clk) begin
        if (!rst && seq_vec !== seen_q) begin
            seen_q = seq_vec;
            if (exp_q.size() == 0) begin
                err_total++;
                $display("[ERR] t=%0t unexpected step %b", $time, seq_vec);
            end else begin
                check_vec(exp_q.pop_front(), seq_vec, "sequence step");
            end
        end
    end

    // Watchdog: the whole run needs well under ten thousand cycles.
    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        $display("[ERR] t=%0t watchdog expired", $time);
        end_of_test();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rnd = $urandom(32'hD70E25EF);
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        climb_from(0);
        drain();
        check_vec(5'b00000, {4'h0, rdy_wire}, "ready pin low");
        check_vec(5'b00000, {4'h0, ref_pd}, "reference released");
        $display("test power-up done");

        // Every rail faults at least once, then random ones.
        for (int n = 0; n < 8; n++) begin
            pick = (n < 4) ? n : int'($urandom % 4);
            push_ones(pick + 1);
            force_low[pick] = 1'b1;
            drain();
            tick(4);
            check_num(1, int'(fault_flags[pick]), "fault flag");
            check_vec(5'b00001, {4'h0, rdy_wire}, "ready pin released");
            climb_from(pick + 1);
            force_low = 4'h0;
            drain();
        end
        $display("test faults done");

        tick(SS_SIM + 50);
        check_vec(5'b11111, {inv_ramp[7:4], dbl_ramp[0]}, "ramps full");
        check_num(255, int'(dbl_ramp & inv_ramp), "ramps full");
        $display("test soft-start done");

        // Boost latch: set on each tick, cleared by a trip until the next.
        // A held trip leaves a one-cycle pulse per tick, which marks the tick edge.
        trip = 1'b1;
        for (k = 0; k < 400 && boost_sw !== 1'b0; k++) tick(1);
        for (k = 0; k < 400 && boost_sw !== 1'b1; k++) tick(1);
        t0 = cyc;
        trip = 1'b0;
        tick(50);
        check_num(1, int'(boost_sw === 1'b1), "switch holds on");
        trip = 1'b1;
        tick(3);
        check_num(0, int'(boost_sw !== 1'b0), "trip clears switch");
        tick(100);
        check_num(0, int'(boost_sw !== 1'b0), "switch stays off");
        for (k = 0; k < 400 && boost_sw !== 1'b1; k++) tick(1);
        check_num(200, cyc - t0, "boost period");
        trip = 1'b0;
        $display("test boost done");

        // Pumps: complementary halves of a 400 cycle period.
        hi_cnt = 0;
        for (int i = 0; i < 400; i++) begin
            tick(1);
            hi_cnt += int'(inv_hi === 1'b1);
            check_vec({2'b00, ~inv_hi, inv_hi, ~inv_hi}, {2'b00, inv_lo, dbl_lo, dbl_hi},
                      "pump phases");
        end
        check_num(200, hi_cnt, "pump half length");
        $display("test pumps done");

        push_ones(0);
        pd_n = 1'b0;
        drain();
        tick(4);
        check_vec(5'b10000, {ref_pd, inv_ramp[0], dbl_ramp[0], boost_sw, ~rdy_wire},
                  "shutdown state");
        climb_from(0);
        pd_n = 1'b1;
        drain();
        $display("test power-down done");
        end_of_test();
    end
endmodule : tb_top

`default_nettype wire

/* tb/trs_stage_model.sv */
// Behavioural model of the power stages around the sequencer: one rail per
// enable, each reporting "up" a set number of cycles after it is enabled.
// Assumes the bench sets the climb delay and may hold any rail down.
`default_nettype none

module trs_stage_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] rail_enable,
    input wire logic [3:0] force_low,
    input wire logic [7:0] delay_cycles,
    output logic [3:0] rail_up
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // Rail charge counters
    // ------------------------------------------------------------------
    logic [7:0] charge_q [4];

    // A disabled or faulted rail collapses at once; slow decay would only
    // delay recovery, and the bench wants clean, predictable climbs.
    // A charged rail parks at FF, so a new climb delay cannot drop a rail
    // that is already up.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                charge_q[i] <= 8'h00;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (!rail_enable[i] || force_low[i]) begin
                    charge_q[i] <= 8'h00;
                end else if (charge_q[i] != 8'hFF) begin
                    charge_q[i] <= (charge_q[i] + 8'h01 >= delay_cycles) ? 8'hFF
                                   : charge_q[i] + 8'h01;
                end
            end
        end
    end

    // A rail counts as up once it has charged for the full delay.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            rail_up[i] = rail_enable[i] && !force_low[i] && (charge_q[i] == 8'hFF);
        end
    end
endmodule : trs_stage_model

`default_nettype wire

/* verilog/trs_pkg.sv */
// Package for the triple rail sequencer and supervisor.
// Assumes one 50 MHz clock and comparator results that are already logic levels.
`default_nettype none

package trs_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 50000000;
    localparam int OSC_HZ = 250000;
    // Clock cycles per oscillator period; the pump period is twice this.
    localparam int OSC_CYCLES = CLK_HZ / OSC_HZ;
    localparam logic [7:0] OSC_LAST = 8'(OSC_CYCLES - 1);
    localparam logic [7:0] OSC_RESET = 8'h00;

    // Charge pump soft-start time in microseconds.
    localparam int SS_TIME_US = 16000;
    localparam int SS_CYCLES = (CLK_HZ / 1000000) * SS_TIME_US;
    // The ramp climbs through this many steps over the soft-start time.
    localparam int SS_STEPS = 255;
    localparam logic [7:0] RAMP_RESET = 8'h00;
    localparam logic [7:0] RAMP_FULL = 8'hFF;
    localparam logic [19:0] SS_CNT_RESET = 20'h00000;

    // ------------------------------------------------------------------
    // Synchroniser layout
    // ------------------------------------------------------------------
    localparam int SYNC_W = 8;
    localparam int IX_PWR = 0;
    localparam int IX_REF_UP = 1;
    localparam int IX_REF_OK = 2;
    localparam int IX_MAIN_UP = 3;
    localparam int IX_MAIN_OK = 4;
    localparam int IX_NEG_UP = 5;
    localparam int IX_NEG_OK = 6;
    localparam int IX_POS_UP = 7;
    localparam logic [SYNC_W-1:0] SYNC_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Sequencer states, in power-up order
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        TRS_OFF = 3'b000,
        TRS_REF = 3'b001,
        TRS_MAIN = 3'b010,
        TRS_NEG = 3'b011,
        TRS_POS = 3'b100,
        TRS_READY = 3'b101
    } trs_state_e;

endpackage : trs_pkg

`default_nettype wire

/* verilog/trs_sequencer.sv */
// Digital control of a triple-output display bias supply: power-down, power-up
// order, fault supervision, open-drain ready and boost and pump switch timing.
// Assumes comparator results arrive as logic levels and the power stages
// outside follow the switch and enable outputs.
`default_nettype none

// Behaviour
// - 250kHz tick sets the boost switch latch.
// - Trip clears latch until next tick.
// - Pumps switch at 125kHz, two half-cycles.
// - Inverting pump: high side, then low side.
// - Doubling pump: low side, then high side.
// - Boost starts at once, no ramp.
// - Pumps ramp up over 16ms soft-start.
// - Power-down disables all, grounds reference.
// - Startup enables reference, then boost.
// - Inverting pump waits for boost regulation.
// - Doubling pump starts below 120mV feedback.
// - Positive above 1.125V asserts ready low.
// - Any fault releases ready output.
// - Reference and boost fault thresholds flagged.
// - Negative and positive pump faults flagged.
// - Fault stops later rails until recovery.
module trs_sequencer #(
    parameter int SS_CYCLES = trs_pkg::SS_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic power_down_n_input,
    input wire logic ref_above_powerup,
    input wire logic ref_above_fault,
    input wire logic boost_feedback_node_in_reg,
    input wire logic boost_feedback_node_above_fault,
    input wire logic negative_pump_feedback_node_below_start,
    input wire logic negative_pump_feedback_node_below_fault,
    input wire logic positive_pump_feedback_node_above_ready,
    input wire logic positive_pump_feedback_node_above_fault,
    input wire logic boost_trip,
    output logic ref_enable,
    output logic ref_pulldown,
    output logic boost_enable,
    output logic boost_switch_on,
    output logic inverting_enable,
    output logic inverting_high_side_on,
    output logic inverting_low_side_on,
    output logic doubling_enable,
    output logic doubling_low_side_on,
    output logic doubling_high_side_on,
    output logic [7:0] inverting_ramp,
    output logic [7:0] doubling_ramp,
    output logic ready_n_out,
    output logic ready_n_oe,
    output logic [3:0] fault_flags
);

    // ------------------------------------------------------------------
    // State record
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] osc_cnt;
        logic osc_tick;
        logic half;
        trs_pkg::trs_state_e state;
        logic ref_en;
        logic ref_pd;
        logic main_en;
        logic boost_sw;
        logic neg_en;
        logic neg_hs;
        logic neg_ls;
        logic pos_en;
        logic pos_ls;
        logic pos_hs;
        logic [19:0] neg_ss;
        logic [19:0] pos_ss;
        logic [7:0] neg_ramp;
        logic [7:0] pos_ramp;
        logic rdy_oe;
        logic [3:0] faults;
    } trs_regs_s;

    localparam logic [19:0] SS_STEP_LAST = 20'((SS_CYCLES / trs_pkg::SS_STEPS) - 1);

    trs_regs_s r_q;
    trs_regs_s r_d;
    logic [trs_pkg::SYNC_W-1:0] cmp_s;

    // ------------------------------------------------------------------
    // Comparator synchronisation
    // ------------------------------------------------------------------
    // synchronised inputs.
    trs_sync #(
        .W(trs_pkg::SYNC_W)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .async_in({positive_pump_feedback_node_above_ready,
                   negative_pump_feedback_node_below_fault,
                   negative_pump_feedback_node_below_start,
                   boost_feedback_node_above_fault,
                   boost_feedback_node_in_reg,
                   ref_above_fault,
                   ref_above_powerup,
                   power_down_n_input}),
        .sync_out(cmp_s)
    );

    // The positive fault comparator does not fit the eight-bit group, so it
    // gets its own one-bit synchroniser with the same two-flop delay.
    logic [0:0] pos_ok_s;
    trs_sync #(
        .W(1)
    ) u_sync_pos (
        .clk(clk),
        .rst(rst),
        .async_in(positive_pump_feedback_node_above_fault),
        .sync_out(pos_ok_s)
    );

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // The boost trip is left unsynchronised: it is a cycle-by-cycle current
    // limit and two cycles of delay would lengthen every switch pulse.
    always_comb begin
        logic ref_flt;
        logic main_flt;
        logic neg_flt;
        logic pos_flt;
        r_d = r_q;
        ref_flt = !cmp_s[trs_pkg::IX_REF_OK];
        main_flt = !cmp_s[trs_pkg::IX_MAIN_OK];
        neg_flt = !cmp_s[trs_pkg::IX_NEG_OK];
        pos_flt = !pos_ok_s[0];

        r_d.osc_tick = (r_q.osc_cnt == trs_pkg::OSC_LAST);
        r_d.osc_cnt = r_d.osc_tick ? trs_pkg::OSC_RESET : r_q.osc_cnt + 8'h01;
        if (r_d.osc_tick) begin
            r_d.half = !r_q.half;
        end

        // Sequencer: TRS_REF to TRS_POS each wait for their rail's power-up threshold.
        unique case (r_q.state)
            trs_pkg::TRS_OFF: begin
                r_d.state = trs_pkg::TRS_REF;
            end
            trs_pkg::TRS_REF: begin
                if (cmp_s[trs_pkg::IX_REF_UP]) begin
                    r_d.state = trs_pkg::TRS_MAIN;
                end
            end
            trs_pkg::TRS_MAIN: begin
                if (cmp_s[trs_pkg::IX_MAIN_UP]) begin
                    r_d.state = trs_pkg::TRS_NEG;
                end
            end
            trs_pkg::TRS_NEG: begin
                if (cmp_s[trs_pkg::IX_NEG_UP]) begin
                    r_d.state = trs_pkg::TRS_POS;
                end
            end
            trs_pkg::TRS_POS: begin
                if (cmp_s[trs_pkg::IX_POS_UP]) begin
                    r_d.state = trs_pkg::TRS_READY;
                end
            end
            trs_pkg::TRS_READY: begin
                r_d.state = trs_pkg::TRS_READY;
            end
            default: begin
                r_d.state = trs_pkg::TRS_OFF;
            end
        endcase

        // earliest faulted rail wins; later rails drop.
        if (r_q.state >= trs_pkg::TRS_MAIN && ref_flt) begin
            r_d.state = trs_pkg::TRS_REF;
        end else if (r_q.state >= trs_pkg::TRS_NEG && main_flt) begin
            r_d.state = trs_pkg::TRS_MAIN;
        end else if (r_q.state >= trs_pkg::TRS_POS && neg_flt) begin
            r_d.state = trs_pkg::TRS_NEG;
        end else if (r_q.state == trs_pkg::TRS_READY && pos_flt) begin
            r_d.state = trs_pkg::TRS_POS;
        end

        if (!cmp_s[trs_pkg::IX_PWR]) begin
            r_d.state = trs_pkg::TRS_OFF;
        end

        // Enables follow the state in power-up order.
        r_d.ref_en = (r_d.state != trs_pkg::TRS_OFF);
        r_d.ref_pd = !r_d.ref_en;
        r_d.main_en = (r_d.state >= trs_pkg::TRS_MAIN);
        r_d.neg_en = (r_d.state >= trs_pkg::TRS_NEG);
        r_d.pos_en = (r_d.state >= trs_pkg::TRS_POS);
        // ready pulled low once sequence completes.
        // any fault releases it via the state fall-back.
        r_d.rdy_oe = (r_d.state == trs_pkg::TRS_READY);
        r_d.faults = {pos_flt, neg_flt, main_flt, ref_flt};

        // boost switches from its first tick, no ramp.
        if (!r_d.main_en) begin
            r_d.boost_sw = 1'b0;
        end else if (r_d.osc_tick) begin
            r_d.boost_sw = 1'b1;
        end else if (boost_trip) begin
            r_d.boost_sw = 1'b0;
        end

        r_d.neg_hs = r_d.neg_en && !r_d.half;
        r_d.neg_ls = r_d.neg_en && r_d.half;
        r_d.pos_ls = r_d.pos_en && !r_d.half;
        r_d.pos_hs = r_d.pos_en && r_d.half;

        // soft-start ramps; each pump restarts its ramp when re-enabled.
        if (!r_d.neg_en) begin
            r_d.neg_ss = trs_pkg::SS_CNT_RESET;
            r_d.neg_ramp = trs_pkg::RAMP_RESET;
        end else if (r_q.neg_ramp != trs_pkg::RAMP_FULL) begin
            if (r_q.neg_ss == SS_STEP_LAST) begin
                r_d.neg_ss = trs_pkg::SS_CNT_RESET;
                r_d.neg_ramp = r_q.neg_ramp + 8'h01;
            end else begin
                r_d.neg_ss = r_q.neg_ss + 20'h00001;
            end
        end
        if (!r_d.pos_en) begin
            r_d.pos_ss = trs_pkg::SS_CNT_RESET;
            r_d.pos_ramp = trs_pkg::RAMP_RESET;
        end else if (r_q.pos_ramp != trs_pkg::RAMP_FULL) begin
            if (r_q.pos_ss == SS_STEP_LAST) begin
                r_d.pos_ss = trs_pkg::SS_CNT_RESET;
                r_d.pos_ramp = r_q.pos_ramp + 8'h01;
            end else begin
                r_d.pos_ss = r_q.pos_ss + 20'h00001;
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Reset holds every rail off with the reference pulled to ground.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r_q <= '{osc_cnt: trs_pkg::OSC_RESET, state: trs_pkg::TRS_OFF, ref_pd: 1'b1,
                     neg_ss: trs_pkg::SS_CNT_RESET, pos_ss: trs_pkg::SS_CNT_RESET,
                     neg_ramp: trs_pkg::RAMP_RESET, pos_ramp: trs_pkg::RAMP_RESET,
                     faults: 4'h0, default: 1'b0};
        end else begin
            r_q <= r_d;
        end
    end

    // Outputs come straight from the state record, except the constant ready_n_out.
    assign ref_enable = r_q.ref_en;
    assign ref_pulldown = r_q.ref_pd;
    assign boost_enable = r_q.main_en;
    assign boost_switch_on = r_q.boost_sw;
    assign inverting_enable = r_q.neg_en;
    assign inverting_high_side_on = r_q.neg_hs;
    assign inverting_low_side_on = r_q.neg_ls;
    assign doubling_enable = r_q.pos_en;
    assign doubling_low_side_on = r_q.pos_ls;
    assign doubling_high_side_on = r_q.pos_hs;
    assign inverting_ramp = r_q.neg_ramp;
    assign doubling_ramp = r_q.pos_ramp;
    assign ready_n_out = 1'b0; // Open drain: only ever pulls low.
    assign ready_n_oe = r_q.rdy_oe;
    assign fault_flags = r_q.faults;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    AST_BOOST_SET_ON_TICK: assert property ($rose(r_q.boost_sw) |-> r_q.osc_tick)
        else $error("boost switch turned on without an oscillator tick");
    AST_TRIP_HOLDS_OFF: assert property (
        r_q.boost_sw && boost_trip && r_q.osc_cnt != trs_pkg::OSC_LAST |=> !r_q.boost_sw)
        else $error("boost switch not cleared by trip");
    AST_TICK_PERIOD: assert property (r_q.osc_tick |=> !r_q.osc_tick [*8])
        else $error("oscillator ticks too close together");
    AST_HALF_ON_TICK: assert property ($changed(r_q.half) |-> r_q.osc_tick)
        else $error("pump half-cycle changed off the tick");
    AST_NEG_PHASE: assert property (
        r_q.neg_en |-> (r_q.neg_hs != r_q.neg_ls) && (r_q.neg_hs == !r_q.half))
        else $error("inverting pump phase wrong");
    AST_POS_PHASE: assert property (
        r_q.pos_en |-> (r_q.pos_ls != r_q.pos_hs) && (r_q.pos_ls == r_q.neg_hs))
        else $error("doubling pump phase wrong");
    AST_BOOST_NO_RAMP: assert property (
        $rose(r_q.main_en) |-> ##[0:200] r_q.boost_sw || !r_q.main_en || boost_trip)
        else $error("boost did not start switching");
    AST_RAMP_STEP: assert property (
        r_q.neg_ramp != $past(r_q.neg_ramp) |-> r_q.neg_ramp == 8'h00
        || r_q.neg_ramp == $past(r_q.neg_ramp) + 8'h01)
        else $error("soft-start ramp jumped");
    AST_SHUTDOWN: assert property (
        !power_down_n_input [*3] |=> !r_q.ref_en && r_q.ref_pd && !r_q.main_en && !r_q.rdy_oe)
        else $error("power-down did not disable rails");
    AST_BOOST_AFTER_REF: assert property (r_q.main_en |-> r_q.ref_en)
        else $error("boost enabled without reference");
    AST_NEG_AFTER_MAIN: assert property ($rose(r_q.neg_en) |-> $past(r_q.main_en))
        else $error("inverting pump enabled before boost");
    AST_POS_AFTER_NEG: assert property ($rose(r_q.pos_en) |-> $past(r_q.neg_en))
        else $error("doubling pump enabled before inverting pump");
    AST_READY_NEEDS_ALL: assert property (r_q.rdy_oe |-> r_q.pos_en && r_q.neg_en)
        else $error("ready asserted before sequence completed");
    AST_FAULT_RELEASES: assert property (
        r_q.rdy_oe && (!cmp_s[trs_pkg::IX_REF_OK] || !cmp_s[trs_pkg::IX_MAIN_OK]
        || !cmp_s[trs_pkg::IX_NEG_OK] || !pos_ok_s[0]) |=> !r_q.rdy_oe)
        else $error("ready held through a fault");
    AST_MAIN_FAULT_DROPS: assert property (
        r_q.neg_en && !cmp_s[trs_pkg::IX_MAIN_OK] && cmp_s[trs_pkg::IX_REF_OK]
        && cmp_s[trs_pkg::IX_PWR] |=> !r_q.neg_en && !r_q.pos_en && r_q.main_en)
        else $error("boost fault did not stop later rails");

    COV_READY: cover property ($rose(r_q.rdy_oe));
    COV_FAULT_RECOVER: cover property ($fell(r_q.pos_en) ##[1:1000] $rose(r_q.pos_en));
    COV_TRIP: cover property ($fell(r_q.boost_sw) && r_q.main_en);

endmodule : trs_sequencer

`default_nettype wire

/* verilog/trs_sync.sv */
// Two-stage synchroniser for a group of comparator levels.
// Assumes the levels change slowly compared with the clock.
`default_nettype none

module trs_sync #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] stage1_q;

    // ------------------------------------------------------------------
    // Two flops; only the second stage is visible outside.
    // ------------------------------------------------------------------
    // comparator synchronisation.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1_q <= '0;
            sync_out <= '0;
        end else begin
            stage1_q <= async_in;
            sync_out <= stage1_q;
        end
    end

endmodule : trs_sync

`default_nettype wire
